// ==== design/acrp_fifo.sv ====
// Result FIFO with registered head word, parameterised width and depth
`timescale 1ns/1ns
module acrp_fifo #(
    parameter int W = 16,     // Word width
    parameter int DEPTH = 8   // Words, power of two
) (
    input wire logic i_clk,   // Core clock
    input wire logic i_nrst,  // Synchronous reset, active low
    acrp_fifo_if.fifo bus     // Fill and drain handshake
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [W-1:0] mem [DEPTH];   // Storage
    logic [AW-1:0] wr_ptr;       // Next write slot
    logic [AW-1:0] rd_ptr;       // Head slot
    logic [AW:0] count;          // Words held
    logic [W-1:0] head;          // Registered head word

    wire push = bus.in_valid && bus.in_ready;
    wire pop = bus.out_valid && bus.out_ready;
    // Pointers wrap naturally since depth is a power of two
    wire [AW-1:0] next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;
    // Word written straight into the new head slot bypasses the array
    wire head_bypass = push && (wr_ptr == next_rd);

    assign bus.in_ready = (count != FULL);
    assign bus.out_valid = (count != '0);
    assign bus.out_data = head;

    // Pointer and fill bookkeeping; flush empties at once
    always_ff @(posedge i_clk) begin
        if (!i_nrst || bus.flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= next_rd;
            unique case ({push, pop})
                2'b10: count <= count + 1'b1;
                2'b01: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end

    // Array write, no reset needed for storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= bus.in_data;
        end
    end

    // Head register so read data leave from a flop
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            head <= '0;
        end else begin
            head <= head_bypass ? bus.in_data : mem[next_rd];
        end
    end
endmodule : acrp_fifo

// ==== design/acrp_fifo_if.sv ====
// Result buffer handshake between the sequencer and the FIFO
`timescale 1ns/1ns
interface acrp_fifo_if #(
    parameter int W = 16
);
    logic in_valid;         // Word offered
    logic in_ready;         // Buffer has room
    logic [W-1:0] in_data;  // Word written
    logic out_valid;        // Head word present
    logic out_ready;        // Consumer takes head
    logic [W-1:0] out_data; // Head word, registered
    logic flush;            // Drop all words

    modport src (
        output in_valid, in_data, out_ready, flush,
        input in_ready, out_valid, out_data
    );
    modport fifo (
        input in_valid, in_data, out_ready, flush,
        output in_ready, out_valid, out_data
    );
endinterface : acrp_fifo_if

// ==== design/acrp_pkg.sv ====
// Shared constants and types for the converter start and result read port
package acrp_pkg;
    localparam int RESULT_W = 16;              // Width of a conversion result
    localparam int BYTE_W = 8;                 // Width of one byte lane
    localparam int VIN_W = 26;                 // Signed microvolt input width
    localparam int SAR_STEPS = 16;             // One trial per result bit
    localparam int IDX_W = 5;                  // Holds 0..SAR_STEPS
    localparam int LSB_UV = 305;               // Microvolts per code step
    localparam int FIFO_DEPTH = 8;             // Result buffer depth
    localparam int SYNC_STAGES = 3;            // Pin synchroniser length
    localparam int NUM_PINS = 3;               // Chip select, strobe, byte select
    localparam int PIN_CS = 0;                 // Position of chip select
    localparam int PIN_RC = 1;                 // Position of read/convert strobe
    localparam int PIN_BYTE = 2;               // Position of byte select
    localparam int CLK_PERIOD_NS = 50;         // Core clock period
    localparam int T_BUS_ACCESS_NS = 83;       // Bus access time
    localparam int READ_GUARD_CYC = (T_BUS_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GUARD_W = 2;                // Holds READ_GUARD_CYC
    localparam logic [NUM_PINS-1:0] RST_PINS = 3'h3; // Idle: deselected, strobe high
    localparam logic RST_BUSY_N = 1'b1;        // Not busy after reset
    localparam logic [RESULT_W-1:0] RST_RESULT = 16'h0000; // Result after reset
    localparam logic [RESULT_W-1:0] SIGN_FLIP = 16'h8000;  // Offset binary to two's complement
    localparam logic [RESULT_W-1:0] CODE_MAX = 16'h7FFF;   // Most positive code
    localparam logic [RESULT_W-1:0] CODE_MIN = 16'h8000;   // Most negative code

    // Conversion sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_PUSH = 4'b0100,
        ST_WAIT = 4'b1000
    } acrp_state_t;
endpackage : acrp_pkg

// ==== design/acrp_top.sv ====
// Conversion start, successive approximation and parallel result read port
`timescale 1ns/1ns
// Operation
// - Busy low from start until result updated
// - Byte select low upper, high lower half
// - Chip select falling with strobe low converts
// - Data bus released unless selected and strobe high
// - Result bus bit 15 most, 0 least
// - One code step equals 305 microvolts
// - Result coded in two's complement
// - Strobe falling converts, strobe rising enables output
// - New command while busy aborts and restarts
module acrp_top (
    input wire logic I_CORE_CLK,                                // Core clock, 20 MHz
    input wire logic I_NRST,                                    // Sync reset, active low
    input wire logic I_CS_N,                                    // Chip select, active low
    input wire logic I_RC,                                      // Read high, convert low
    input wire logic I_BYTE,                                    // Byte select
    input wire logic signed [acrp_pkg::VIN_W-1:0] I_VIN_UV,     // Held input, microvolts
    output logic O_BUSY_N,                                      // Busy, active low
    output logic [acrp_pkg::RESULT_W-1:0] O_DATA,               // Result bus
    output logic O_DATA_OE                                      // Result bus drive enable
);
    import acrp_pkg::*;

    // Assertions below all run on the core clock and pause in reset
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_NRST);

    // Pin synchronisers and filtered levels
    wire [NUM_PINS-1:0] pin_raw = {I_BYTE, I_RC, I_CS_N}; // Raw pins
    wire [NUM_PINS-1:0] pin_lvl;                         // Filtered levels

    // Control decode
    logic cmd_prev;                    // Convert command one cycle ago
    logic read_prev;                   // Read enable one cycle ago
    acrp_state_t state;                // Sequencer state
    acrp_state_t next_state;           // Sequencer next state
    logic signed [VIN_W-1:0] vin_held; // Sampled input in hold
    logic [RESULT_W-1:0] trial;        // Offset binary approximation
    logic [IDX_W-1:0] idx;             // Bits already decided
    logic [RESULT_W-1:0] result;       // Output register
    logic [GUARD_W-1:0] guard;         // Read window stall count

    acrp_fifo_if #(.W(RESULT_W)) fbus ();

    // Pins come from outside the clock domain
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++) begin : g_sync
            logic [SYNC_STAGES-1:0] sh; // Shift chain, bit 0 first
            logic lvl;                  // Accepted level
            // Level moves only when the last two stages agree
            always_ff @(posedge I_CORE_CLK) begin
                if (!I_NRST) begin
                    sh <= {SYNC_STAGES{RST_PINS[g]}};
                    lvl <= RST_PINS[g];
                end else begin
                    sh <= {sh[SYNC_STAGES-2:0], pin_raw[g]};
                    if (sh[SYNC_STAGES-1] == sh[SYNC_STAGES-2]) begin
                        lvl <= sh[SYNC_STAGES-1];
                    end
                end
            end
            assign pin_lvl[g] = lvl;
        end
    endgenerate

    wire cs_lvl = pin_lvl[PIN_CS];     // High means deselected
    wire rc_lvl = pin_lvl[PIN_RC];     // High read, low convert
    wire byte_lvl = pin_lvl[PIN_BYTE]; // High picks lower half

    // Select and strobe are ORed: both low is the convert level
    wire cmd_lvl = !cs_lvl && !rc_lvl;
    wire cmd_rise = cmd_lvl && !cmd_prev;
    wire read_lvl = !cs_lvl && rc_lvl;
    wire read_rise = read_lvl && !read_prev;

    wire st_idle = (state == ST_IDLE);
    wire st_conv = (state == ST_CONV);
    wire st_push = (state == ST_PUSH);
    wire st_wait = (state == ST_WAIT);

    // One trial per cycle, most significant bit first
    wire sar_done = (idx == IDX_W'(SAR_STEPS));
    wire [RESULT_W-1:0] sar_bit = RESULT_W'(SIGN_FLIP >> idx);
    wire [RESULT_W-1:0] test = trial | sar_bit;
    // Trial voltage is the signed code times the step size
    wire signed [VIN_W-1:0] test_code = VIN_W'($signed(test ^ SIGN_FLIP));
    wire signed [VIN_W-1:0] step_uv = VIN_W'(LSB_UV);
    wire signed [VIN_W-1:0] test_uv = test_code * step_uv;
    wire keep_bit = (vin_held >= test_uv);
    // Flipping the top bit turns offset binary into two's complement
    wire [RESULT_W-1:0] code = trial ^ SIGN_FLIP;

    // Output register takes the head word unless a read is just opening
    wire load_out = fbus.out_valid && (guard == '0);

    assign fbus.in_valid = st_push;
    assign fbus.in_data = code;
    assign fbus.out_ready = (guard == '0);
    // A fresh command drops any result that was not yet published
    assign fbus.flush = cmd_rise;

    // Sequencer next state
    always_comb begin
        next_state = state;
        if (cmd_rise) begin
            next_state = ST_CONV;
        end else begin
            unique case (state)
                ST_IDLE: next_state = ST_IDLE;
                ST_CONV: next_state = sar_done ? ST_PUSH : ST_CONV;
                ST_PUSH: next_state = fbus.in_ready ? ST_WAIT : ST_PUSH;
                ST_WAIT: next_state = load_out ? ST_IDLE : ST_WAIT;
            endcase
        end
    end

    // State and edge history
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            state <= ST_IDLE;
            cmd_prev <= 1'b0;
            read_prev <= 1'b0;
        end else begin
            state <= next_state;
            cmd_prev <= cmd_lvl;
            read_prev <= read_lvl;
        end
    end

    // Approximation register; a command restarts from the top bit
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            trial <= '0;
            idx <= '0;
            vin_held <= '0;
        end else if (cmd_rise) begin
            trial <= '0;
            idx <= '0;
            vin_held <= I_VIN_UV;
        end else if (st_conv && !sar_done) begin
            trial <= keep_bit ? test : trial;
            idx <= idx + 1'b1;
        end
    end

    // Stall drain briefly while the bus is opening so data stay stable
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            guard <= '0;
        end else if (read_rise) begin
            guard <= GUARD_W'(READ_GUARD_CYC);
        end else if (guard != '0) begin
            guard <= guard - 1'b1;
        end
    end

    // Busy drops on a command and rises with the output update
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            O_BUSY_N <= RST_BUSY_N;
            result <= RST_RESULT;
        end else if (cmd_rise) begin
            O_BUSY_N <= 1'b0;
        end else if (load_out) begin
            result <= fbus.out_data;
            O_BUSY_N <= 1'b1;
        end
    end

    // Result bus; bit 15 is the most significant, byte select swaps halves
    wire [RESULT_W-1:0] swapped = {result[BYTE_W-1:0], result[RESULT_W-1:BYTE_W]};
    wire [RESULT_W-1:0] next_data = byte_lvl ? swapped : result;
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            O_DATA <= RST_RESULT;
            O_DATA_OE <= 1'b0;
        end else begin
            O_DATA <= next_data;
            O_DATA_OE <= read_lvl;
        end
    end

    acrp_fifo #(.W(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .bus(fbus)
    );

    // Checks on the sequencer and the bus

    // Helper bounds for the step check
    wire signed [VIN_W-1:0] code_uv = VIN_W'($signed(code)) * step_uv;
    wire signed [VIN_W-1:0] code_hi_uv = code_uv + step_uv;

    sequence s_start;
        cmd_rise ##1 (st_conv && !O_BUSY_N);
    endsequence
    sequence s_abort;
        cmd_rise && !O_BUSY_N && !st_idle;
    endsequence

    property p_busy_start;
        cmd_rise |=> !O_BUSY_N;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not low after start");

    property p_busy_hold;
        s_start |-> !O_BUSY_N [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy rose during conversion");

    property p_busy_rise;
        $rose(O_BUSY_N) |-> $past(load_out) && (result == $past(fbus.out_data));
    endproperty
    a_busy_rise: assert property (p_busy_rise) else $error("busy rose without update");

    property p_byte_sel;
        O_DATA_OE |-> O_DATA == ($past(byte_lvl) ?
            {$past(result[BYTE_W-1:0]), $past(result[RESULT_W-1:BYTE_W])} : $past(result));
    endproperty
    a_byte_sel: assert property (p_byte_sel) else $error("wrong byte on bus");

    property p_cs_start;
        $fell(cs_lvl) && !rc_lvl |=> st_conv && (idx == '0);
    endproperty
    a_cs_start: assert property (p_cs_start) else $error("select edge did not convert");

    property p_bus_off;
        (cs_lvl || !rc_lvl) |=> !O_DATA_OE;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus driven while released");

    property p_msb;
        O_DATA_OE && !$past(byte_lvl) |-> O_DATA[RESULT_W-1] == $past(result[RESULT_W-1]);
    endproperty
    a_msb: assert property (p_msb) else $error("sign not on top bit");

    property p_step;
        st_push && (code != CODE_MAX) && (code != CODE_MIN) |->
            (vin_held >= code_uv) && (vin_held < code_hi_uv);
    endproperty
    a_step: assert property (p_step) else $error("code outside its step");

    property p_sign;
        st_push |-> code[RESULT_W-1] == vin_held[VIN_W-1];
    endproperty
    a_sign: assert property (p_sign) else $error("sign coding wrong");

    property p_rc_edges;
        ($fell(rc_lvl) && !cs_lvl && O_BUSY_N |=> st_conv) and
        ($rose(rc_lvl) && !cs_lvl |=> O_DATA_OE);
    endproperty
    a_rc_edges: assert property (p_rc_edges) else $error("strobe edge ignored");

    property p_abort;
        s_abort |=> st_conv && (idx == '0) && (trial == '0) && !O_BUSY_N;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not restart");

    // An abort may land anywhere in the trials; otherwise push comes on cycle 17
    property p_conv_len;
        s_start |-> (##[1:16] cmd_rise) or (##17 st_push);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    // Further checks on busy, buffering, trial stepping, bus drive and restart
    property p_idle_busy;
        st_idle |-> O_BUSY_N;
    endproperty
    a_idle_busy: assert property (p_idle_busy) else $error("busy low while idle");

    property p_busy_fall;
        $fell(O_BUSY_N) |-> $past(cmd_rise);
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fell without command");

    property p_push_step;
        st_push && fbus.in_ready && !cmd_rise |=> st_wait && fbus.out_valid;
    endproperty
    a_push_step: assert property (p_push_step) else $error("result not buffered");

    property p_load;
        load_out && !cmd_rise |=> O_BUSY_N && (result == $past(fbus.out_data));
    endproperty
    a_load: assert property (p_load) else $error("load did not release busy");

    property p_idx_step;
        st_conv && !sar_done && !cmd_rise |=> (idx == $past(idx) + 1'b1);
    endproperty
    a_idx_step: assert property (p_idx_step) else $error("trial skipped");

    property p_bus_on;
        read_lvl |=> O_DATA_OE;
    endproperty
    a_bus_on: assert property (p_bus_on) else $error("bus not driven in read");

    property p_lsb;
        O_DATA_OE && !$past(byte_lvl) |-> O_DATA[0] == $past(result[0]);
    endproperty
    a_lsb: assert property (p_lsb) else $error("lowest bit misplaced");

    property p_sample;
        cmd_rise |=> (vin_held == $past(I_VIN_UV));
    endproperty
    a_sample: assert property (p_sample) else $error("input not held at start");

    property p_flush;
        cmd_rise |=> !fbus.out_valid;
    endproperty
    a_flush: assert property (p_flush) else $error("stale result kept");
endmodule : acrp_top

// ==== sim/acrp_host_model.sv ====
// Host controller model that starts conversions and reads results
`timescale 1ns/1ns
module acrp_host_model import acrp_pkg::*; (
    input wire logic i_clk, // Core clock
    input wire logic i_busy_n, // Busy from device, active low
    input wire logic i_oe, // Device drive enable
    input wire logic [acrp_pkg::RESULT_W-1:0] i_bus, // Resolved data bus
    output logic o_cs_n = 1'b1, // Chip select, active low
    output logic o_rc = 1'b1, // Read high, convert low
    output logic o_byte = 1'b0, // Byte select
    output logic signed [acrp_pkg::VIN_W-1:0] o_vin_uv = '0 // Held input, microvolts
);
    logic [1:0] busy_sync; // Busy after two host flops

    // Busy is foreign to a real host clock, so it is sampled twice
    always_ff @(posedge i_clk) begin
        busy_sync <= {busy_sync[0], i_busy_n};
    end

    // Convert command; pins held well past the device pin filter
    task automatic convert(input logic signed [VIN_W-1:0] v, input logic cs_last,
                           output logic oe);
        @(negedge i_clk);
        o_vin_uv = v;
        if (cs_last) begin
            o_rc = 1'b0; // Strobe first, select starts it
        end else begin
            o_cs_n = 1'b0; // Select first, opens a read window
            repeat (6) @(negedge i_clk);
        end
        @(negedge i_clk);
        o_cs_n = 1'b0;
        o_rc = 1'b0;
        repeat (7) @(negedge i_clk);
        oe = i_oe;
        o_cs_n = 1'b1;
        o_rc = 1'b1;
        // Short idle pulses may be filtered away, so leave a gap
        repeat (3) @(negedge i_clk);
    endtask : convert

    // Waits, bounded, for synchronised busy to go high again
    task automatic wait_idle(output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 200; n++) begin
            @(negedge i_clk);
            if (busy_sync[1] === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
    endtask : wait_idle

    // Read window with the given byte select, then deselect
    task automatic read(input logic b, output logic [RESULT_W-1:0] d, output logic oe);
        @(negedge i_clk);
        o_byte = b;
        o_cs_n = 1'b0;
        o_rc = 1'b1;
        repeat (6) @(negedge i_clk);
        d = i_bus;
        oe = i_oe;
        o_cs_n = 1'b1;
        repeat (6) @(negedge i_clk);
    endtask : read

    // Select tied low: strobe alone converts, then its rise reopens the bus
    task automatic convert_tied(input logic signed [VIN_W-1:0] v, output logic oe,
                                output logic [RESULT_W-1:0] d, output logic ok);
        @(negedge i_clk);
        o_vin_uv = v;
        o_byte = 1'b0;
        o_cs_n = 1'b0;
        o_rc = 1'b1;
        repeat (6) @(negedge i_clk);
        o_rc = 1'b0;
        repeat (7) @(negedge i_clk);
        o_rc = 1'b1;
        repeat (6) @(negedge i_clk);
        oe = i_oe;
        // Bus stays open; data are taken only once busy is back high
        wait_idle(ok);
        @(negedge i_clk);
        d = i_bus;
        o_cs_n = 1'b1;
        repeat (6) @(negedge i_clk);
    endtask : convert_tied
endmodule : acrp_host_model

// ==== sim/acrp_tb_top.sv ====
// Self-checking testbench for the converter start and result read port
`timescale 1ns/1ns
module acrp_tb_top import acrp_pkg::*;;
    localparam int TIMEOUT_CYC = 5000; // Whole run needs about 600 cycles
    localparam int MIN_LOW = SAR_STEPS + 2; // Trials, done and push cycles
    logic clk = 1'b0; // Core clock
    logic nrst = 1'b0; // Sync reset, active low
    logic cs_n; // Chip select from host
    logic rc; // Strobe from host
    logic byte_sel; // Byte select from host
    logic signed [VIN_W-1:0] vin; // Held input
    logic busy_n; // Busy from device
    logic [RESULT_W-1:0] data; // Device result bus
    logic data_oe; // Device drive enable
    logic [RESULT_W-1:0] last_drv = '0; // Last driven bus value
    wire [RESULT_W-1:0] bus; // Resolved bus seen by host
    int n_fail = 0; // Mismatches
    int checks_done = 0; // Comparisons
    int cycles = 0; // Clock cycles run
    int low_run = 0; // Current busy low run
    int last_run = 0; // Length of last finished busy low run

    // Released bus shows the inverse of its last value, never a stale match
    assign bus = data_oe ? data : ~last_drv;

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // Bus history, busy run length and hang guard
    always @(posedge clk) begin
        if (data_oe === 1'b1) begin
            last_drv <= data;
        end
        if (busy_n === 1'b0) begin
            low_run <= low_run + 1;
        end else begin
            if (low_run != 0) last_run <= low_run;
            low_run <= 0;
        end
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYC) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    acrp_top i_dut (
        .I_CORE_CLK(clk), .I_NRST(nrst), .I_CS_N(cs_n), .I_RC(rc), .I_BYTE(byte_sel),
        .I_VIN_UV(vin), .O_BUSY_N(busy_n), .O_DATA(data), .O_DATA_OE(data_oe)
    );

    acrp_host_model i_host (
        .i_clk(clk), .i_busy_n(busy_n), .i_oe(data_oe), .i_bus(bus),
        .o_cs_n(cs_n), .o_rc(rc), .o_byte(byte_sel), .o_vin_uv(vin)
    );

    // Expected code: floor of microvolts over step size, clamped
    function automatic logic [RESULT_W-1:0] code_of(input int v);
        int q;
        q = v / LSB_UV;
        if (v < 0 && q * LSB_UV != v) q = q - 1;
        if (q > 32767) q = 32767;
        if (q < -32768) q = -32768;
        return q[RESULT_W-1:0];
    endfunction : code_of

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // Reset with pins idle; outputs must show their reset levels
    task automatic apply_reset;
        nrst = 1'b0;
        repeat (16) @(negedge clk);
        chk(busy_n, RST_BUSY_N);
        chk(data_oe, 1'b0);
        chk(data, RST_RESULT);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        $display("test reset done");
    endtask : apply_reset

    // Both byte orders, then the bus must be released
    task automatic read_both(input logic [RESULT_W-1:0] exp);
        logic oe;
        logic [RESULT_W-1:0] d;
        i_host.read(1'b0, d, oe);
        chk(oe, 1'b1);
        chk(d, exp);
        i_host.read(1'b1, d, oe);
        chk(d, {exp[7:0], exp[15:8]});
        chk(data_oe, 1'b0);
    endtask : read_both

    task automatic conv_read(input int v, input logic cs_last);
        logic oe;
        logic ok;
        last_run = 0;
        i_host.convert(v[VIN_W-1:0], cs_last, oe);
        chk(oe, 1'b0);
        i_host.wait_idle(ok);
        chk(ok, 1'b1);
        chk(last_run >= MIN_LOW && last_run <= MIN_LOW + 8, 1'b1);
        read_both(code_of(v));
    endtask : conv_read

    // Codes at zero, small negatives, both clamps; both start orders
    task automatic t_codes;
        int vals [7] = '{0, 305000, -1, -305, 9999999, -10000000, 1234567};
        for (int i = 0; i < 7; i++) begin
            conv_read(vals[i], i[0]);
        end
        $display("test codes done");
    endtask : t_codes

    // Second command while busy: one long busy run, second value wins
    task automatic t_abort;
        logic oe;
        logic ok;
        last_run = 0;
        i_host.convert(26'sd305000, 1'b1, oe);
        i_host.convert(-26'sd305000, 1'b1, oe);
        i_host.wait_idle(ok);
        chk(ok, 1'b1);
        chk(last_run >= MIN_LOW + 6, 1'b1);
        read_both(code_of(-305000));
        $display("test abort done");
    endtask : t_abort

    // Reset in mid conversion, then a clean conversion afterwards
    task automatic t_reset_mid;
        logic oe;
        i_host.convert(26'sd3050, 1'b1, oe);
        apply_reset();
        conv_read(-3050, 1'b0);
        $display("test mid reset done");
    endtask : t_reset_mid

    // Select held low: strobe edges alone convert and open the bus
    task automatic t_tied;
        logic oe;
        logic ok;
        logic [RESULT_W-1:0] d;
        i_host.convert_tied(-26'sd61001, oe, d, ok);
        chk(oe, 1'b1);
        chk(ok, 1'b1);
        chk(d, code_of(-61001));
        chk(data_oe, 1'b0);
        $display("test tied select done");
    endtask : t_tied

    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        apply_reset();
        t_codes();
        t_abort();
        t_tied();
        t_reset_mid();
        final_report();
    end
endmodule : acrp_tb_top
